// ---- arfi_pkg.sv ----
// Package for the range, sample-buffer and interrupt configuration block.
// Assumes a single clock domain; register access is a plain byte port.
package arfi_pkg;
  localparam logic [7:0] ADDR_RESULT_FIRST = 8'h02;
  localparam logic [7:0] ADDR_RESULT_LAST = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RANGE_CTRL = 8'h15;
  localparam logic [7:0] ADDR_BUF_CTRL = 8'h16;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h17;
  localparam logic [7:0] ADDR_STARTUP = 8'h1a;
  localparam logic [7:0] RESET_RANGE_CTRL = 8'h00;
  localparam logic [7:0] RESET_BUF_CTRL = 8'h00;
  localparam logic [7:0] RESET_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RESET_STARTUP = 8'h00;
  // Field positions
  localparam int WIDTH_SEL_LSB = 0;
  localparam int RANGE_SEL_LSB = 4;
  localparam int TRIP_LSB = 0;
  localparam int POLICY_BIT = 5;
  localparam int BUF_EN_BIT = 6;
  localparam int BUF_CLR_BIT = 7;
  localparam int PIN_DRIVE_BIT = 0;
  localparam int POLARITY_BIT = 1;
  localparam int WAKE_EN_BIT = 2;
  localparam int NEW_EN_BIT = 3;
  localparam int DRAINED_EN_BIT = 4;
  localparam int FILLED_EN_BIT = 5;
  localparam int TRIP_EN_BIT = 6;
  localparam int WATCH_EN_BIT = 7;
  // Status flag positions (0x08)
  localparam int ST_DRAINED_BIT = 0;
  localparam int ST_FILLED_BIT = 1;
  localparam int ST_TRIP_BIT = 2;
  localparam int ST_NEW_BIT = 3;
  // Width codes
  localparam logic [2:0] WSEL_6 = 3'h0;
  localparam logic [2:0] WSEL_7 = 3'h1;
  localparam logic [2:0] WSEL_8 = 3'h2;
  localparam logic [2:0] WSEL_10 = 3'h3;
  localparam logic [2:0] WSEL_12 = 3'h4;
  localparam logic [2:0] WSEL_14 = 3'h5;
  localparam int BUF_DEPTH = 32;
  localparam int BUF_WIDTH = 12;
  localparam int SAMPLE_WIDTH = 14;

  typedef enum logic [4:0] {
    ARFI_G2 = 5'b00001,
    ARFI_G4 = 5'b00010,
    ARFI_G8 = 5'b00100,
    ARFI_G16 = 5'b01000,
    ARFI_G12 = 5'b10000
  } arfi_range_e;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arfi_bus_s;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_WIDTH-1:0] x;
    logic [SAMPLE_WIDTH-1:0] y;
    logic [SAMPLE_WIDTH-1:0] z;
  } arfi_sample_s;
endpackage

// ---- arfi_width_fmt.sv ----
// Sign-extending sample formatter for the selected width; the 14-bit code gives 12 bits when buf_en is set.
// Assumes raw samples are left-aligned 14-bit two's complement.
`timescale 1ns/1ps
module arfi_width_fmt (
  // Control
  input wire logic [2:0] width_sel,
  input wire logic buf_en,
  // Data
  input wire logic [13:0] raw,
  output logic [15:0] result
);
  import arfi_pkg::*;

  function automatic logic [15:0] sext(input logic [13:0] v, input int n);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = (i < n) ? v[14 - n + i] : v[13];
    end
    return r;
  endfunction

  always_comb begin
    case (width_sel)
      WSEL_6: result = sext(raw, 6);
      WSEL_7: result = sext(raw, 7);
      WSEL_8: result = sext(raw, 8);
      WSEL_10: result = sext(raw, 10);
      WSEL_12: result = sext(raw, 12);
      WSEL_14: result = buf_en ? sext(raw, 12) : sext(raw, 14);
      default: result = 16'h0000;
    endcase
  end
endmodule

// ---- arfi_sample_buf.sv ----
// Sample buffer, depth and width parameterised, with asynchronous clear.
// Assumes the write enable is already gated by the buffer enable.
`timescale 1ns/1ps
module arfi_sample_buf #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // Clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic clr,
  input wire logic ce,
  // Write side
  input wire logic wr,
  input wire logic [WIDTH-1:0] wdata,
  output logic wr_ready,
  // Read side
  input wire logic rd,
  output logic [WIDTH-1:0] rdata,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic do_wr;
  logic do_rd;

  assign wr_ready = (count != (AW+1)'(DEPTH));
  assign do_wr = wr && wr_ready;
  assign do_rd = rd && (count != '0);

  always_ff @(posedge clk or posedge reset or posedge clr) begin
    if (reset || clr) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (ce) begin
      if (do_wr) begin
        mem[wptr] <= wdata;
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        rptr <= rptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  assign rdata = mem[rptr];
endmodule

// ---- arfi_cfg.sv ----
// Range, sample-buffer and interrupt configuration registers of the sensor.
// Assumes a byte register port from the serial engine and a one-cycle
// new-sample strobe from the sensing datapath.
`timescale 1ns/1ps
module arfi_cfg (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire arfi_pkg::arfi_bus_s bus,
  output logic [7:0] rdata,
  // Sample and event inputs
  input wire arfi_pkg::arfi_sample_s sample,
  input wire logic wake_event,
  input wire logic activity_event,
  input wire logic in_watch_while_active_mode,
  input wire logic activity_clear_in,
  input wire logic [7:0] status_clear,
  // Buffer read port for the serial engine
  input wire logic buf_rd,
  // Configuration outputs
  output arfi_pkg::arfi_range_e range_sel,
  output logic [7:0] startup_word,
  output logic activity_reset,
  output logic sample_accepted,
  // Interrupt pin
  output logic irq_pin_o,
  output logic irq_pin_oe
);
  import arfi_pkg::*;

  logic [7:0] range_resolution_control;
  logic [7:0] sample_buffer_control;
  logic [7:0] interrupt_enable_control;
  logic [7:0] startup_fixed_word;
  logic [15:0] res_x;
  logic [15:0] res_y;
  logic [15:0] res_z;
  logic [15:0] out_x;
  logic [15:0] out_y;
  logic [15:0] out_z;
  logic [5:0] count;
  logic [11:0] buf_rdata;
  logic buf_ready;
  logic buf_en;
  logic buf_clr;
  logic [4:0] trip;
  logic trip_hit;
  logic buf_wr;
  logic drained;
  logic filled;
  logic new_flag;
  logic wake_flag;
  logic watch_flag;
  logic irq_any;
  logic [2:0] width_sel;

  assign width_sel = range_resolution_control[WIDTH_SEL_LSB +: 3];
  assign buf_en = sample_buffer_control[BUF_EN_BIT];
  assign buf_clr = sample_buffer_control[BUF_CLR_BIT];
  assign trip = sample_buffer_control[TRIP_LSB +: 5];
  assign startup_word = startup_fixed_word;

  function automatic arfi_range_e dec_range(input logic [2:0] c);
    case (c)
      3'h0: return ARFI_G2;
      3'h1: return ARFI_G4;
      3'h2: return ARFI_G8;
      3'h3: return ARFI_G16;
      3'h4: return ARFI_G12;
      default: return ARFI_G2;
    endcase
  endfunction

  // Register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      range_resolution_control <= RESET_RANGE_CTRL;
      sample_buffer_control <= RESET_BUF_CTRL;
      interrupt_enable_control <= RESET_IRQ_CTRL;
      startup_fixed_word <= RESET_STARTUP;
    end else if (ce && bus.we) begin
      case (bus.addr)
        ADDR_RANGE_CTRL: range_resolution_control <= bus.wdata & 8'h77;
        ADDR_BUF_CTRL: sample_buffer_control <= bus.wdata;
        ADDR_IRQ_CTRL: interrupt_enable_control <= bus.wdata;
        ADDR_STARTUP: startup_fixed_word <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Range decode held in a register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      range_sel <= ARFI_G2;
    end else if (ce) begin
      range_sel <= dec_range(range_resolution_control[RANGE_SEL_LSB +: 3]);
    end
  end

  // Activity detector clear follows the register level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      activity_reset <= 1'b0;
    end else if (ce) begin
      activity_reset <= activity_clear_in;
    end
  end

  arfi_width_fmt u_fx (.width_sel(width_sel), .buf_en(buf_en),
    .raw(sample.x), .result(res_x));
  arfi_width_fmt u_fy (.width_sel(width_sel), .buf_en(buf_en),
    .raw(sample.y), .result(res_y));
  arfi_width_fmt u_fz (.width_sel(width_sel), .buf_en(buf_en),
    .raw(sample.z), .result(res_z));

  // Sample acceptance
  assign trip_hit = buf_en && (count >= {1'b0, trip});
  always_comb begin
    buf_wr = 1'b0;
    if (buf_en && sample.valid && buf_ready) begin
      buf_wr = sample_buffer_control[POLICY_BIT] ? !trip_hit : 1'b1;
    end
  end
  assign sample_accepted = buf_wr || (!buf_en && sample.valid);

  arfi_sample_buf #(.WIDTH(BUF_WIDTH), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .reset(reset),
    .clr(buf_clr),
    .ce(ce),
    .wr(buf_wr),
    .wdata(res_x[11:0]),
    .wr_ready(buf_ready),
    .rd(buf_rd && buf_en),
    .rdata(buf_rdata),
    .count(count)
  );

  // Output result registers, direct path when buffering is off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_x <= 16'h0000;
      out_y <= 16'h0000;
      out_z <= 16'h0000;
    end else if (ce && sample.valid && !buf_en) begin
      out_x <= res_x;
      out_y <= res_y;
      out_z <= res_z;
    end
  end

  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      new_flag <= 1'b0;
      wake_flag <= 1'b0;
      watch_flag <= 1'b0;
    end else if (ce) begin
      new_flag <= sample_accepted ||
        (new_flag && !status_clear[ST_NEW_BIT]);
      wake_flag <= wake_event || (wake_flag && !status_clear[4]);
      watch_flag <= (activity_event && in_watch_while_active_mode) ||
        (watch_flag && !status_clear[5]);
    end
  end

  // Buffer level flags, defaults while disabled
  assign drained = buf_en ? (count == 6'd0) : 1'b1;
  assign filled = buf_en && (count == 6'(BUF_DEPTH));

  always_comb begin
    irq_any = 1'b0;
    if (interrupt_enable_control[NEW_EN_BIT] && new_flag) irq_any = 1'b1;
    if (interrupt_enable_control[WAKE_EN_BIT] && wake_flag) irq_any = 1'b1;
    if (interrupt_enable_control[WATCH_EN_BIT] && watch_flag)
      irq_any = 1'b1;
    if (buf_en) begin
      if (interrupt_enable_control[DRAINED_EN_BIT] && drained)
        irq_any = 1'b1;
      if (interrupt_enable_control[FILLED_EN_BIT] && filled)
        irq_any = 1'b1;
      if (interrupt_enable_control[TRIP_EN_BIT] && trip_hit)
        irq_any = 1'b1;
    end
  end

  // Pin drive
  logic irq_level;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_level <= 1'b0;
    end else if (ce) begin
      irq_level <= irq_any;
    end
  end
  always_comb begin
    if (interrupt_enable_control[PIN_DRIVE_BIT]) begin
      irq_pin_oe = 1'b1;
      irq_pin_o = interrupt_enable_control[POLARITY_BIT] ?
        irq_level : !irq_level;
    end else begin
      irq_pin_o = 1'b0;
      irq_pin_oe = interrupt_enable_control[POLARITY_BIT] ?
        1'b0 : irq_level;
    end
  end

  // Read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (ce && bus.re) begin
      case (bus.addr)
        8'h02: rdata <= buf_en ? buf_rdata[7:0] : out_x[7:0];
        8'h03: rdata <= buf_en ? {{4{buf_rdata[11]}}, buf_rdata[11:8]}
          : out_x[15:8];
        8'h04: rdata <= out_y[7:0];
        8'h05: rdata <= out_y[15:8];
        8'h06: rdata <= out_z[7:0];
        ADDR_RESULT_LAST: rdata <= out_z[15:8];
        ADDR_STATUS: rdata <= {4'h0, new_flag, trip_hit, filled, drained};
        ADDR_RANGE_CTRL: rdata <= range_resolution_control;
        ADDR_BUF_CTRL: rdata <= sample_buffer_control;
        ADDR_IRQ_CTRL: rdata <= interrupt_enable_control;
        ADDR_STARTUP: rdata <= startup_fixed_word;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Assertions
  sequence s_full;
    buf_en && count == 6'd32;
  endsequence
  a_full_blocks_write: assert property (@(posedge clk) disable iff (reset)
    s_full |-> !buf_wr) else $error("write into full buffer");
  a_policy_drop: assert property (@(posedge clk) disable iff (reset)
    sample_buffer_control[POLICY_BIT] && trip_hit |-> !buf_wr)
    else $error("sample taken past trip");
  a_disabled_no_write: assert property (@(posedge clk) disable iff (reset)
    !buf_en |-> !buf_wr) else $error("buffer written while off");
  a_drained_default: assert property (@(posedge clk) disable iff (reset)
    !buf_en |-> drained && !filled) else $error("flag default");
  a_irq_follows: assert property (@(posedge clk) disable iff (reset)
    ce && irq_any |=> irq_level) else $error("irq level lag");
  a_push_pull_pol: assert property (@(posedge clk) disable iff (reset)
    interrupt_enable_control[1:0] == 2'b01 |-> irq_pin_o == !irq_level)
    else $error("active low drive wrong");
  a_open_drain: assert property (@(posedge clk) disable iff (reset)
    !interrupt_enable_control[0] |-> !irq_pin_o)
    else $error("open drain drove high");
  a_new_sticky: assert property (@(posedge clk) disable iff (reset)
    ce && sample_accepted |=> new_flag) else $error("new flag lost");
  a_count_bound: assert property (@(posedge clk) disable iff (reset)
    count <= 6'd32) else $error("count overrun");
  a_full_flag: assert property (@(posedge clk) disable iff (reset)
    s_full |-> filled) else $error("full flag missing");
  a_trip_irq: assert property (@(posedge clk) disable iff (reset)
    ce && trip_hit && interrupt_enable_control[TRIP_EN_BIT] |=> irq_level)
    else $error("trip irq missing");
  a_drained_irq: assert property (@(posedge clk) disable iff (reset)
    ce && buf_en && interrupt_enable_control[DRAINED_EN_BIT] &&
    count == 6'd0 |=> irq_level) else $error("drained irq missing");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (reset)
    ce && !buf_en && interrupt_enable_control[7:2] == 6'b011100 |=>
    !irq_level) else $error("buffer irq while off");
  a_range_decode: assert property (@(posedge clk) disable iff (reset)
    ce && range_resolution_control[6:4] == 3'h4 |=> range_sel == ARFI_G12)
    else $error("range decode wrong");
  a_open_drain_low: assert property (@(posedge clk) disable iff (reset)
    interrupt_enable_control[1:0] == 2'b00 |-> irq_pin_oe == irq_level)
    else $error("open drain pull wrong");
endmodule

// ---- arfi_host_model.sv ----
// Host model: byte register port and interrupt pin with pull-up.
// Assumes requests start after reset release, one clock domain.
`timescale 1ns/1ps
module arfi_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output arfi_pkg::arfi_bus_s bus,
  input wire logic [7:0] rdata,
  // Interrupt pin
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe,
  output logic irq_level
);
  import arfi_pkg::*;
  // Released pin floats to the pull-up
  assign irq_level = irq_pin_oe ? irq_pin_o : 1'b1;
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 bus = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 bus = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 bus = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 bus = '0;
    d = rdata;
  endtask
  task automatic init();
    wr(ADDR_STARTUP, 8'h00);
  endtask
endmodule

// ---- tb_arfi_cfg.sv ----
// Testbench for the range, buffer and interrupt configuration block.
// Assumes a host model on the register port and a pulled-up irq pin.
`timescale 1ns/1ps
module tb_arfi_cfg;
  import arfi_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  arfi_bus_s bus;
  logic [7:0] rdata;
  arfi_sample_s sample = '0;
  logic wake_ev = 1'b0;
  logic act_ev = 1'b0;
  logic watch_mode = 1'b0;
  logic act_clr = 1'b0;
  logic [7:0] status_clear = 8'h00;
  logic buf_rd = 1'b0;
  arfi_range_e range_sel;
  logic [7:0] startup_word;
  logic activity_reset;
  logic sample_accepted;
  logic irq_pin_o;
  logic irq_pin_oe;
  logic irq_level;
  int fail_count = 0;
  int checks = 0;
  always #25 clk = ~clk;
  arfi_cfg dut (.clk(clk), .reset(reset), .ce(1'b1), .bus(bus),
    .rdata(rdata), .sample(sample), .wake_event(wake_ev),
    .activity_event(act_ev), .in_watch_while_active_mode(watch_mode),
    .activity_clear_in(act_clr), .status_clear(status_clear),
    .buf_rd(buf_rd), .range_sel(range_sel), .startup_word(startup_word),
    .activity_reset(activity_reset), .sample_accepted(sample_accepted),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
  arfi_host_model host (.clk(clk), .bus(bus), .rdata(rdata),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .irq_level(irq_level));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, m, exp);
    logic [7:0] d;
    host.rd(a, d);
    chk({8'h00, d & m}, {8'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pin_is(input logic v);
    for (int i = 0; i < 6 && irq_level !== v; i++) @(posedge clk);
    #1 chk({15'h0, irq_level}, {15'h0, v});
  endtask
  task automatic send(input logic [13:0] x, output logic acc);
    @(posedge clk);
    #1 sample = '{valid: 1'b1, x: x, y: 14'h0, z: 14'h0};
    #1 acc = sample_accepted;
    @(posedge clk);
    #1 sample.valid = 1'b0;
  endtask
  task automatic sclr(input logic [7:0] m);
    @(posedge clk);
    #1 status_clear = m;
    @(posedge clk);
    #1 status_clear = 8'h00;
  endtask
  task automatic evt(input logic wake);
    @(posedge clk);
    #1 if (wake) wake_ev = 1'b1; else act_ev = 1'b1;
    @(posedge clk);
    #1 wake_ev = 1'b0;
    act_ev = 1'b0;
  endtask
  task automatic t_reset();
    rdchk(ADDR_RANGE_CTRL, 8'hff, RESET_RANGE_CTRL);
    rdchk(ADDR_BUF_CTRL, 8'hff, RESET_BUF_CTRL);
    rdchk(ADDR_IRQ_CTRL, 8'hff, RESET_IRQ_CTRL);
    rdchk(ADDR_STARTUP, 8'hff, RESET_STARTUP);
    chk({8'h00, startup_word}, 16'h0000);
    rdchk(8'h30, 8'hff, 8'h00);
    pin_is(1'b1);
    $display("test reset done");
  endtask
  task automatic t_range();
    for (int i = 0; i < 5; i++) begin
      host.wr(ADDR_RANGE_CTRL, 8'(i << RANGE_SEL_LSB));
      tick(1);
      #1 chk({11'h0, range_sel}, 16'h1 << i);
    end
    host.wr(ADDR_RANGE_CTRL, 8'hff);
    rdchk(ADDR_RANGE_CTRL, 8'hff, 8'h77);
    $display("test range done");
  endtask
  task automatic t_width();
    int w[6] = '{6, 7, 8, 10, 12, 14};
    logic a;
    logic [7:0] lo;
    logic [7:0] hi;
    for (int c = 0; c < 6; c++) begin
      host.wr(ADDR_RANGE_CTRL, 8'(c));
      send(14'h2000, a);
      host.rd(ADDR_RESULT_FIRST, lo);
      host.rd(8'h03, hi);
      chk({hi, lo}, 16'hffff << (w[c] - 1));
      send(14'h1fff, a);
      host.rd(ADDR_RESULT_FIRST, lo);
      host.rd(8'h03, hi);
      chk({hi, lo}, ~(16'hffff << (w[c] - 1)));
    end
    $display("test width done");
  endtask
  task automatic t_buf();
    logic a;
    logic [7:0] lo;
    logic [7:0] hi;
    int n = 0;
    host.wr(ADDR_BUF_CTRL, 8'h80);
    host.wr(ADDR_RANGE_CTRL, 8'h05);
    host.wr(ADDR_BUF_CTRL, 8'h63);
    for (int i = 0; i < 5; i++) begin
      send(14'h2000, a);
      n += int'(a === 1'b1);
      if (i == 0) begin
        host.rd(ADDR_RESULT_FIRST, lo);
        host.rd(8'h03, hi);
        chk({hi, lo}, 16'hf800);
      end
    end
    chk(16'(n), 16'd3);
    rdchk(ADDR_STATUS, 8'h04, 8'h04);
    host.wr(ADDR_IRQ_CTRL, 8'h40);
    pin_is(1'b0);
    host.wr(ADDR_BUF_CTRL, 8'h80);
    host.wr(ADDR_BUF_CTRL, 8'h5f);
    rdchk(ADDR_STATUS, 8'h03, 8'h01);
    n = 0;
    for (int i = 0; i < 33; i++) begin
      send(14'(i), a);
      n += int'(a === 1'b1);
    end
    chk(16'(n), 16'(BUF_DEPTH));
    rdchk(ADDR_STATUS, 8'h03, 8'h02);
    host.wr(ADDR_IRQ_CTRL, 8'h10);
    tick(4);
    pin_is(1'b1);
    host.wr(ADDR_IRQ_CTRL, 8'h20);
    pin_is(1'b0);
    for (int i = 0; i < BUF_DEPTH; i++) begin
      host.rd(ADDR_RESULT_FIRST, lo);
      chk({8'h00, lo}, 16'(i >> 2));
      @(posedge clk);
      #1 buf_rd = 1'b1;
      @(posedge clk);
      #1 buf_rd = 1'b0;
    end
    host.wr(ADDR_IRQ_CTRL, 8'h10);
    pin_is(1'b0);
    rdchk(ADDR_STATUS, 8'h03, 8'h01);
    $display("test buffer done");
  endtask
  task automatic t_irq();
    logic a;
    host.wr(ADDR_BUF_CTRL, 8'h03);
    host.wr(ADDR_IRQ_CTRL, 8'h70);
    tick(4);
    pin_is(1'b1);
    sclr(8'h38);
    host.wr(ADDR_IRQ_CTRL, 8'h0b);
    pin_is(1'b0);
    send(14'h0001, a);
    pin_is(1'b1);
    sclr(8'h08);
    pin_is(1'b0);
    host.wr(ADDR_IRQ_CTRL, 8'h08);
    send(14'h0002, a);
    pin_is(1'b0);
    sclr(8'h08);
    pin_is(1'b1);
    host.wr(ADDR_IRQ_CTRL, 8'h80);
    evt(1'b0);
    tick(4);
    pin_is(1'b1);
    watch_mode = 1'b1;
    evt(1'b0);
    pin_is(1'b0);
    sclr(8'h20);
    pin_is(1'b1);
    host.wr(ADDR_IRQ_CTRL, 8'h04);
    evt(1'b1);
    pin_is(1'b0);
    sclr(8'h10);
    pin_is(1'b1);
    act_clr = 1'b1;
    tick(5);
    #1 chk({15'h0, activity_reset}, 16'h1);
    act_clr = 1'b0;
    tick(2);
    #1 chk({15'h0, activity_reset}, 16'h0);
    $display("test irq done");
  endtask
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    tick(4);
    #1 reset = 1'b0;
    host.init();
    t_reset();
    t_range();
    t_width();
    t_buf();
    t_irq();
    close_out();
  end
endmodule
